// ==== lms_regs.vh ====
// Register map, field positions, reset values and widths of the light measurement control bank
`ifndef LMS_REGS_VH
`define LMS_REGS_VH

// Register indices; the byte address on the bus is four times the index
`define LMS_IDX_MODDIS 8'h40
`define LMS_IDX_ENABLE 8'h80
`define LMS_IDX_MODE1 8'h81
`define LMS_IDX_MODE2 8'h82
`define LMS_ADDR_W 12

// Modulator disable fields
`define LMS_MODDIS_M1 1
`define LMS_MODDIS_M0 0
`define LMS_MODDIS_MASK 8'h03

// Function enable fields
`define LMS_EN_FLICKER 6
`define LMS_EN_LIGHT 1
`define LMS_EN_POWER 0
`define LMS_EN_MASK 8'h43

// First mode register fields
`define LMS_M1_AUTOSTOP 7
`define LMS_M1_DBLDROP 6
`define LMS_M1_SINGLE 5
`define LMS_M1_STATFIFO 4
`define LMS_M1_SCALE_HI 3
`define LMS_M1_SCALE_LO 0

// Second mode register fields
`define LMS_M2_ENDMARK 7
`define LMS_M2_CHKSUM 6
`define LMS_M2_GAINFIFO 5
`define LMS_M2_TOP_HI 4
`define LMS_M2_TOP_LO 0

// Reset values
`define LMS_RST_MODDIS 8'h00
`define LMS_RST_ENABLE 8'h00
`define LMS_RST_MODE1 8'h04
`define LMS_RST_MODE2 8'h0C

// Result geometry
`define LMS_RES_W 32
`define LMS_RES_USED 26
`define LMS_OUT_W 16
`define LMS_GAIN_W 4
`define LMS_ITER_W 8

`endif

// ==== lms_ctrl.v ====
// Control and mode register bank of the light measurement engine with APB slave
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lms_regs.vh"

module lms_ctrl (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`LMS_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Measurement engine events
  input wire measDone,
  input wire flickerDone,
  input wire satEvent,
  input wire gainUp,
  input wire endlessFlickerRepeat,
  input wire [`LMS_ITER_W-1:0] iterTarget,
  input wire resultValid,
  input wire [`LMS_RES_W-1:0] rawResult,
  // Engine controls
  output reg oscRun,
  output reg firstModulatorOn,
  output reg secondModulatorOn,
  output reg lightMeasureActive,
  output reg flickerActive,
  output reg sleepAfterIrq,
  output reg [`LMS_GAIN_W-1:0] agcGain,
  // FIFO extra words
  output reg fifoStatusWr,
  output reg fifoEndMarkWr,
  output reg fifoChecksumWr,
  output reg fifoGainWr,
  // Scaled result
  output reg [`LMS_OUT_W-1:0] lightData,
  output reg lightDataScaled
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Sixteen bits of the result word ending at bit position top
  function [`LMS_OUT_W-1:0] window16;
    input [`LMS_RES_W-1:0] raw;
    input integer top;
    integer i;
    integer idx;
    begin
      window16 = {`LMS_OUT_W{1'b0}};
      for (i = 0; i < `LMS_OUT_W; i = i + 1) begin
        idx = top - (`LMS_OUT_W - 1) + i;
        if (idx >= 0 && idx < `LMS_RES_W)
          window16[i] = raw[idx];
      end
    end
  endfunction

  // True when the cnt bits from top downward are all zero
  function topZero;
    input [`LMS_RES_W-1:0] raw;
    input integer top;
    input integer cnt;
    integer i;
    begin
      topZero = 1'b1;
      for (i = 0; i < `LMS_RES_W; i = i + 1) begin
        if (i <= top && i > top - cnt && raw[i])
          topZero = 1'b0;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Host-visible register contents
  reg [7:0] modDis_r;
  reg [7:0] enable_r;
  reg [7:0] mode1_r;
  reg [7:0] mode2_r;
  reg [`LMS_ITER_W-1:0] iterCnt_r;
  reg [7:0] rdNxt;
  reg mapped;
  wire [7:0] regIdx = paddr[9:2];
  wire setupPhase = psel & ~penable & ~pready;
  wire wrTake = psel & penable & pready & pwrite;
  wire [3:0] scaleCnt = mode1_r[`LMS_M1_SCALE_HI:`LMS_M1_SCALE_LO];
  wire [4:0] topSel = mode2_r[`LMS_M2_TOP_HI:`LMS_M2_TOP_LO];
  // Only the low 26 bits carry result; anything above is treated as zero
  wire [`LMS_RES_W-1:0] usedResult = rawResult & {{(`LMS_RES_W-`LMS_RES_USED){1'b0}}, {`LMS_RES_USED{1'b1}}};
  // Top of the scaled window; it may fall below zero, those bits then read as zero
  wire signed [6:0] scaledTop = $signed({2'b00, topSel}) - $signed({3'b000, scaleCnt});
  wire powered = enable_r[`LMS_EN_POWER];
  wire lastIter = (iterCnt_r == iterTarget);
  // Auto-stop fires on a measurement end that finds the count already at the target
  wire autoStop = mode1_r[`LMS_M1_AUTOSTOP] & measDone & lastIter & powered;

  // Read decode; reserved bits come back as zero
  always @* begin
    mapped = 1'b1;
    rdNxt = 8'h00;
    case (regIdx)
      `LMS_IDX_MODDIS: rdNxt = modDis_r;
      `LMS_IDX_ENABLE: rdNxt = enable_r;
      `LMS_IDX_MODE1: rdNxt = mode1_r;
      `LMS_IDX_MODE2: rdNxt = mode2_r;
      default: mapped = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00 || paddr[`LMS_ADDR_W-1:10] != 2'b00)
      mapped = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait-free access phase, data latched at setup
  // A setup cycle seen at one edge raises pready for exactly the next cycle, so
  // every transfer has one access cycle; the write lands at the edge that samples
  // pready high, while psel, penable and the address are all still held

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPhase;
      if (setupPhase) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdNxt};
        pslverr <= ~mapped;
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      modDis_r <= `LMS_RST_MODDIS;
      enable_r <= `LMS_RST_ENABLE;
      mode1_r <= `LMS_RST_MODE1;
      mode2_r <= `LMS_RST_MODE2;
    end else begin
      // auto-stop drop
      // Clears both enables but leaves power set; a same-cycle write wins
      if (autoStop) begin
        enable_r[`LMS_EN_FLICKER] <= 1'b0;
        enable_r[`LMS_EN_LIGHT] <= 1'b0;
      end
      if (wrTake && mapped) begin
        case (regIdx)
          `LMS_IDX_MODDIS: modDis_r <= pwdata[7:0] & `LMS_MODDIS_MASK;
          `LMS_IDX_ENABLE: begin
            if (!pwdata[`LMS_EN_POWER])
              enable_r <= 8'h00;
            else
              enable_r <= pwdata[7:0] & `LMS_EN_MASK;
          end
          `LMS_IDX_MODE1: mode1_r <= pwdata[7:0];
          `LMS_IDX_MODE2: mode2_r <= pwdata[7:0];
          default: modDis_r <= modDis_r;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Iteration counter for auto-stop, restarted whenever measuring is idle

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      iterCnt_r <= {`LMS_ITER_W{1'b0}};
    end else if (!(enable_r[`LMS_EN_LIGHT] | enable_r[`LMS_EN_FLICKER]) || autoStop) begin
      iterCnt_r <= {`LMS_ITER_W{1'b0}};
    end else if (measDone && !lastIter) begin
      // Counting stops at the target so a late event cannot run past it
      iterCnt_r <= iterCnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine control outputs

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      oscRun <= 1'b0;
      firstModulatorOn <= 1'b0;
      secondModulatorOn <= 1'b0;
      lightMeasureActive <= 1'b0;
      flickerActive <= 1'b0;
      sleepAfterIrq <= 1'b0;
    end else begin
      oscRun <= powered;
      firstModulatorOn <= powered & ~modDis_r[`LMS_MODDIS_M0];
      secondModulatorOn <= powered & ~modDis_r[`LMS_MODDIS_M1];
      lightMeasureActive <= powered & enable_r[`LMS_EN_LIGHT];
      flickerActive <= powered & enable_r[`LMS_EN_FLICKER];
      // single shot sleep
      // Held until single shot is cleared or power drops
      if (!powered || !mode1_r[`LMS_M1_SINGLE])
        sleepAfterIrq <= 1'b0;
      else if (measDone)
        sleepAfterIrq <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Automatic gain step

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      agcGain <= {`LMS_GAIN_W{1'b0}};
    end else if (satEvent) begin
      // Saturation wins over a same-cycle step-up request
      // double step down
      // Floors at zero so a drop of two from step one cannot wrap
      if (mode1_r[`LMS_M1_DBLDROP] && agcGain > 4'h1)
        agcGain <= agcGain - 4'h2;
      else if (agcGain != 4'h0)
        agcGain <= agcGain - 4'h1;
    end else if (gainUp && agcGain != 4'hF) begin
      agcGain <= agcGain + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extra FIFO word requests, one-cycle pulses

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      fifoStatusWr <= 1'b0;
      fifoEndMarkWr <= 1'b0;
      fifoChecksumWr <= 1'b0;
      fifoGainWr <= 1'b0;
    end else begin
      // Each request stands one cycle; the FIFO writer takes it at the next edge
      // status word
      fifoStatusWr <= resultValid & powered & mode1_r[`LMS_M1_STATFIFO];
      fifoEndMarkWr <= flickerDone & powered & mode2_r[`LMS_M2_ENDMARK] & ~endlessFlickerRepeat;
      fifoChecksumWr <= flickerDone & powered & mode2_r[`LMS_M2_CHKSUM];
      fifoGainWr <= flickerDone & powered & mode2_r[`LMS_M2_GAINFIFO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result scaling into the 16-bit data word

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      lightData <= {`LMS_OUT_W{1'b0}};
      lightDataScaled <= 1'b0;
    end else if (resultValid) begin
      // only the low 26 bits carry result
      // window ends at selected top bit
      // scaled when top bits zero
      // Scaled form skips the zero bits to keep resolution
      if (scaleCnt != 4'h0 && topZero(usedResult, topSel, scaleCnt)) begin
        lightData <= window16(usedResult, scaledTop);
        lightDataScaled <= 1'b1;
      end else begin
        lightData <= window16(usedResult, topSel);
        lightDataScaled <= 1'b0;
      end
    end
  end

endmodule // lms_ctrl
`default_nettype wire

// ==== lms_ctrl_assertions.sv ====
// Port checker for the light measurement control bank
`timescale 1ns/1ps
`default_nettype none
module lms_ctrl_assertions (
  // Clock, reset and bus answer
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  // Engine events
  input wire logic measDone,
  input wire logic flickerDone,
  input wire logic satEvent,
  input wire logic resultValid,
  input wire logic endlessFlickerRepeat,
  // Engine controls
  input wire logic oscRun,
  input wire logic firstModulatorOn,
  input wire logic secondModulatorOn,
  input wire logic lightMeasureActive,
  input wire logic flickerActive,
  input wire logic sleepAfterIrq,
  input wire logic [3:0] agcGain,
  input wire logic fifoStatusWr,
  input wire logic fifoEndMarkWr,
  input wire logic fifoChecksumWr,
  input wire logic fifoGainWr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Nothing runs without the oscillator
  a_mods_need_power: assert property (!oscRun |-> !firstModulatorOn && !secondModulatorOn)
    else $error("modulator on without power");
  a_enables_need_power: assert property (!oscRun |-> !lightMeasureActive && !flickerActive)
    else $error("measurement active without power");
  // Gain never wraps below zero, and always drops on saturation when above zero
  a_sat_at_floor: assert property (satEvent && agcGain == 4'h0 |=> agcGain == 4'h0)
    else $error("gain moved at zero on saturation");
  a_sat_steps_down: assert property (satEvent && agcGain != 4'h0 |=> agcGain < $past(agcGain))
    else $error("gain not lowered on saturation");
  // Extra FIFO words only follow their cause
  a_chksum_cause: assert property (fifoChecksumWr |-> $past(flickerDone))
    else $error("checksum word without flicker end");
  a_gainword_cause: assert property (fifoGainWr |-> $past(flickerDone))
    else $error("gain word without flicker end");
  a_status_cause: assert property (fifoStatusWr |-> $past(resultValid))
    else $error("status word without result");
  a_endless_nomark: assert property ($past(endlessFlickerRepeat) |-> !fifoEndMarkWr)
    else $error("end marker in endless repeat");
  a_sleep_cause: assert property ($rose(sleepAfterIrq) |-> $past(measDone))
    else $error("sleep set without a measurement end");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
endmodule // lms_ctrl_assertions
bind lms_ctrl lms_ctrl_assertions i_lms_ctrl_assertions (.*);
`default_nettype wire

// ==== lms_apb_host.sv ====
// APB host model that programs the control bank
`timescale 1ns/1ps
`default_nettype none
module lms_apb_host (
  // Clock
  input wire logic ref_clk,
  // Request
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [11:0] paddr,
  output var logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle until the first request
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // One transfer; waits on pready with no own limit, the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Released data must not look valid
  endtask
endmodule // lms_apb_host
`default_nettype wire

// ==== test_light_meas_enable_mode_ctrl.sv ====
// Self-checking bench of the light measurement control bank
`timescale 1ns/1ps
`default_nettype none
module test_light_meas_enable_mode_ctrl;
  logic ref_clk = 1'b0, sys_rst = 1'b1, psel, penable, pwrite, pready, pslverr, er, endless = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, raw = '0;
  logic [4:0] ev = '0;
  logic [7:0] iter = '0;
  wire oscRun, m0, m1, light, flick, sleepIrq, stW, emW, ckW, gnW, scaled;
  wire [3:0] gain;
  wire [15:0] lightData;
  logic [28:0] rows [9];
  int bad_count = 0, n_checks = 0, cyc = 0;
  lms_apb_host i_lms_apb_host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  lms_ctrl i_lms_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .measDone(ev[4]), .flickerDone(ev[3]), .satEvent(ev[2]), .gainUp(ev[1]), .resultValid(ev[0]),
    .endlessFlickerRepeat(endless), .iterTarget(iter), .rawResult(raw), .oscRun(oscRun),
    .firstModulatorOn(m0), .secondModulatorOn(m1), .lightMeasureActive(light), .flickerActive(flick),
    .sleepAfterIrq(sleepIrq), .agcGain(gain), .fifoStatusWr(stW), .fifoEndMarkWr(emW),
    .fifoChecksumWr(ckW), .fifoGainWr(gnW), .lightData(lightData), .lightDataScaled(scaled));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    i_lms_apb_host.xfer(1'b1, a, {24'h000000, d}, rd, er);
  endtask
  // Event pulse of one cycle; returns just after the edge that samples it
  task automatic pulse(input logic [4:0] m, input logic [31:0] r);
    @(posedge ref_clk);
    ev <= m;
    raw <= r;
    @(posedge ref_clk);
    ev <= 5'h00;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Rows: write flag, address, write data, expected read
  initial begin
    rows = '{{1'b0, 12'h100, 8'h00, 8'h00}, {1'b0, 12'h200, 8'h00, 8'h00}, {1'b0, 12'h204, 8'h00, 8'h04},
      {1'b0, 12'h208, 8'h00, 8'h0C}, {1'b1, 12'h100, 8'hFF, 8'h03}, {1'b1, 12'h204, 8'hA5, 8'hA5},
      {1'b1, 12'h208, 8'hFF, 8'hFF}, {1'b1, 12'h200, 8'hFF, 8'h43}, {1'b1, 12'h200, 8'h42, 8'h00}};
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][28]) wr(rows[i][27:16], rows[i][15:8]);
      i_lms_apb_host.xfer(1'b0, rows[i][27:16], 32'h0, rd, er);
      chk("reg read", {24'h000000, rows[i][7:0]}, rd);
    end
    wr(12'h100, 8'h01);
    wr(12'h204, 8'h14);
    wr(12'h208, 8'hEC);
    wr(12'h200, 8'h43);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("oscRun", 1, oscRun);
    chk("mod0", 0, m0);
    chk("mod1", 1, m1);
    chk("light", 1, light);
    chk("flick", 1, flick);
    pulse(5'h01, 32'h00000123);
    chk("data", 32'h9180, lightData);
    chk("scaled", 1, scaled);
    chk("status", 1, stW);
    pulse(5'h01, 32'h00001000);
    chk("data", 32'h8000, lightData);
    chk("scaled", 0, scaled);
    pulse(5'h08, 32'h0);
    chk("endmark", 1, emW);
    chk("chksum", 1, ckW);
    chk("gainword", 1, gnW);
    @(posedge ref_clk) endless <= 1'b1;
    pulse(5'h08, 32'h0);
    chk("endmark", 0, emW);
    chk("chksum", 1, ckW);
    repeat (3) pulse(5'h02, 32'h0);
    chk("gain", 3, gain);
    wr(12'h204, 8'h44);
    pulse(5'h04, 32'h0);
    chk("gain", 1, gain);
    pulse(5'h04, 32'h0);
    chk("gain", 0, gain);
    @(posedge ref_clk) iter <= 8'h01;
    wr(12'h204, 8'h80);
    pulse(5'h10, 32'h0);
    i_lms_apb_host.xfer(1'b0, 12'h200, 32'h0, rd, er);
    chk("enable", 32'h43, rd);
    pulse(5'h10, 32'h0);
    i_lms_apb_host.xfer(1'b0, 12'h200, 32'h0, rd, er);
    chk("enable", 32'h01, rd);
    chk("light", 0, light);
    chk("flick", 0, flick);
    chk("oscRun", 1, oscRun);
    wr(12'h204, 8'h20);
    pulse(5'h10, 32'h0);
    chk("sleep", 1, sleepIrq);
    i_lms_apb_host.xfer(1'b0, 12'h300, 32'h0, rd, er);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    // Power off stops the oscillator, the modulators and the sleep request
    wr(12'h200, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("oscRun", 0, oscRun);
    chk("mod1", 0, m1);
    chk("sleep", 0, sleepIrq);
    // Reset in mid-run brings the mode registers and the data word back
    @(posedge ref_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    i_lms_apb_host.xfer(1'b0, 12'h208, 32'h0, rd, er);
    chk("mode2 reset", 32'h0C, rd);
    chk("data reset", 0, lightData);
    tally_and_finish();
  end
endmodule // test_light_meas_enable_mode_ctrl
`default_nettype wire
